//--- design/afc_pkg.sv
package afc_pkg;

	// ****************************************
	// Framing constants
	// ****************************************
	localparam logic [7:0] START_DELIM  = 8'h7e; // Frame start
	localparam logic [7:0] ESC_BYTE     = 8'h7d; // Escape marker
	localparam logic [7:0] XON_BYTE     = 8'h11; // Flow-control byte
	localparam logic [7:0] XOFF_BYTE    = 8'h13; // Flow-control byte
	localparam logic [7:0] ESC_XOR      = 8'h20; // Escape flip mask
	localparam logic [7:0] CSUM_GOOD    = 8'hff; // Valid running sum
	localparam logic [7:0] CSUM_BASE    = 8'hff; // Checksum minuend
	localparam logic [7:0] STAT_TYPE    = 8'h8a; // Status frame type
	localparam logic [7:0] STAT_BADSUM  = 8'h01; // Checksum failure
	localparam logic [7:0] STAT_ABORT   = 8'h02; // Frame aborted
	localparam logic [15:0] STAT_LEN    = 16'h0002; // Status payload size

	// ****************************************
	// Modes
	// ****************************************
	localparam logic [1:0] MODE_TRANSP  = 2'h0; // Passthrough
	localparam logic [1:0] MODE_FRAMED  = 2'h1; // Framed
	localparam logic [1:0] MODE_ESCAPED = 2'h2; // Framed with escapes

	// Byte with a last-of-frame mark
	typedef struct packed {
		logic [7:0] data; // Byte value
		logic       last; // Final byte of frame
	} afc_beat_s;

endpackage

//--- design/afc_fifo.sv
`timescale 1ns/10ps
module afc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];    // Storage
	logic [AW-1:0]    wr_q, wr_d;       // Write index
	logic [AW-1:0]    rd_q, rd_d;       // Read index
	logic [AW:0]      cnt_q, cnt_d;     // Fill level
	logic             push, pop;        // Transfers

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Index arithmetic with wrap at depth
	always_comb
	begin
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (push)
			wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
		if (pop)
			rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	// Registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		if (push)
			mem_q[wr_q] <= in_data;
	end

endmodule

//--- design/afc_codec.sv
// Operation
// - Modes: transparent default, framed, framed escaped
// - Framed packets flow both directions
// - 0x7E delimiter starts every frame
// - Drop bytes before delimiter silently
// - Two-byte big-endian data length
// - First data byte is frame type
// - Multi-byte values sent MSB first
// - Checksum is 0xFF minus data sum
// - Accept when data plus checksum sums 0xFF
// - Bad checksum frame data not delivered; here only its last byte is withheld
// - Bad frame triggers status frame back
// - In escaped mode, unescaped 0x7E aborts, restarts frame
// - Escape 7E, 7D, 11, 13 after delimiter
// - Escape is 0x7D then byte xor 0x20
// - Length, checksum use unescaped values
`timescale 1ns/10ps
module afc_codec #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Mode select
	input  wire logic [1:0] framing_mode_select,
	// Serial-side receive bytes (from host)
	input  wire logic       ser_rx_valid,
	input  wire logic [7:0] ser_rx_data,
	// Serial-side transmit bytes (to host)
	output logic            ser_tx_valid,
	input  wire logic       ser_tx_ready,
	output logic      [7:0] ser_tx_data,
	// Unframed payload to device core
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_last,
	output logic            rx_good,
	output logic            rx_bad,
	// Payload from device core to frame
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last
);

	// ****************************************
	// Receive framer
	// ****************************************
	typedef enum logic [2:0] {
		RX_HUNT, RX_LEN_HI, RX_LEN_LO, RX_DATA, RX_SUM
	} afc_rx_e;

	// Beat carrier shared with the delivery FIFO
	typedef afc_pkg::afc_beat_s afc_beat_s;

	afc_rx_e    rs_q, rs_d;          // Receive state
	logic [15:0] rlen_q, rlen_d;     // Bytes left
	logic [7:0]  rsum_q, rsum_d;     // Running sum
	logic        resc_q, resc_d;     // Escape pending
	logic        rbuf_v_q, rbuf_v_d; // Held byte waits
	logic [7:0]  rbuf_q, rbuf_d;     // Held data byte
	logic        good_q, good_d;     // Good pulse
	logic        bad_q, bad_d;       // Bad pulse
	logic        st_req_q, st_req_d; // Status wanted
	logic [7:0]  st_code_q, st_code_d; // Status reason
	logic        fifo_in_v;          // Push to delivery FIFO
	logic        fifo_in_rdy;        // FIFO room
	afc_beat_s   fifo_in;            // Delivered beat
	afc_beat_s   fifo_out;           // Drained beat
	logic        framed;             // Any framed mode
	logic        escmode;            // Escaping mode
	logic        rx_take;            // Byte accepted
	logic [7:0]  rb;                 // Unescaped byte
	logic        rb_ok;              // Byte counts
	logic        st_ack;             // Status request taken

	assign framed  = framing_mode_select != afc_pkg::MODE_TRANSP;
	assign escmode = framing_mode_select == afc_pkg::MODE_ESCAPED;
	// Host bytes have no back-pressure; a full FIFO loses the byte
	assign rx_take = ser_rx_valid;

	// Receive decode and checksum
	always_comb
	begin
		rs_d      = rs_q;
		rlen_d    = rlen_q;
		rsum_d    = rsum_q;
		resc_d    = resc_q;
		rbuf_v_d  = rbuf_v_q;
		rbuf_d    = rbuf_q;
		good_d    = 1'b0;
		bad_d     = 1'b0;
		// A new request below wins over the transmitter's clear
		st_req_d  = st_req_q && !st_ack;
		st_code_d = st_code_q;
		fifo_in_v = 1'b0;
		fifo_in   = '{data: ser_rx_data, last: 1'b0};
		rb        = ser_rx_data;
		rb_ok     = 1'b1;
		// Unescape: drop 0x7D, flip the next byte
		if (escmode && resc_q)
			rb = ser_rx_data ^ afc_pkg::ESC_XOR;
		if (escmode && !resc_q && ser_rx_data == afc_pkg::ESC_BYTE)
			rb_ok = 1'b0;
		if (!framed)
		begin
			// Transparent passthrough
			rs_d      = RX_HUNT;
			fifo_in_v = rx_take;
			fifo_in   = '{data: ser_rx_data, last: 1'b1};
		end
		else if (rx_take)
		begin
			if (escmode && !resc_q
				&& ser_rx_data == afc_pkg::START_DELIM)
			begin
				// Unescaped delimiter restarts reception
				if (rs_q != RX_HUNT)
				begin
					st_req_d  = 1'b1;
					st_code_d = afc_pkg::STAT_ABORT;
					bad_d     = rbuf_v_q;
				end
				rbuf_v_d = 1'b0;
				rs_d     = RX_LEN_HI;
				resc_d   = 1'b0;
			end
			else if (!rb_ok)
				resc_d = 1'b1;
			else
			begin
				resc_d = 1'b0;
				case (rs_q)
					RX_HUNT:
						// Leading junk is dropped
						if (ser_rx_data == afc_pkg::START_DELIM)
							rs_d = RX_LEN_HI;
					RX_LEN_HI:
					begin
						rlen_d[15:8] = rb;
						rs_d         = RX_LEN_LO;
					end
					RX_LEN_LO:
					begin
						rlen_d[7:0] = rb;
						rsum_d      = '0;
						rs_d        = (rlen_q[15:8] == '0 && rb == '0)
							? RX_SUM : RX_DATA;
					end
					RX_DATA:
					begin
						// Hold one byte so the last can be flagged
						rsum_d = rsum_q + rb;
						rlen_d = rlen_q - 16'h0001;
						if (rbuf_v_q)
						begin
							fifo_in_v = 1'b1;
							fifo_in   = '{data: rbuf_q, last: 1'b0};
						end
						rbuf_d   = rb;
						rbuf_v_d = 1'b1;
						if (rlen_q == 16'h0001)
							rs_d = RX_SUM;
					end
					default:
					begin
						// Checksum decides release of the held byte
						rs_d     = RX_HUNT;
						rbuf_v_d = 1'b0;
						if (8'(rsum_q + rb) == afc_pkg::CSUM_GOOD)
						begin
							fifo_in_v = rbuf_v_q;
							fifo_in   = '{data: rbuf_q, last: 1'b1};
							good_d    = 1'b1;
						end
						else
						begin
							bad_d     = 1'b1;
							st_req_d  = 1'b1;
							st_code_d = afc_pkg::STAT_BADSUM;
						end
					end
				endcase
			end
		end
	end

	// Receive registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rs_q      <= RX_HUNT;
			rlen_q    <= '0;
			rsum_q    <= '0;
			resc_q    <= 1'b0;
			rbuf_v_q  <= 1'b0;
			rbuf_q    <= '0;
			good_q    <= 1'b0;
			bad_q     <= 1'b0;
			st_req_q  <= 1'b0;
			st_code_q <= '0;
		end
		else
		begin
			rs_q      <= rs_d;
			rlen_q    <= rlen_d;
			rsum_q    <= rsum_d;
			resc_q    <= resc_d;
			rbuf_v_q  <= rbuf_v_d;
			rbuf_q    <= rbuf_d;
			good_q    <= good_d;
			bad_q     <= bad_d;
			st_req_q  <= st_req_d;
			st_code_q <= st_code_d;
		end
	end

	// Delivery FIFO toward the core
	afc_fifo #(.WIDTH($bits(afc_beat_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (fifo_in_v),
		.in_ready  (fifo_in_rdy),
		.in_data   (fifo_in),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (fifo_out)
	);
	assign rx_data = fifo_out.data;
	assign rx_last = fifo_out.last;
	assign rx_good = good_q;
	assign rx_bad  = bad_q;

	// ****************************************
	// Transmit framer
	// ****************************************
	typedef enum logic [2:0] {
		TX_IDLE, TX_DELIM, TX_LEN_HI, TX_LEN_LO, TX_DATA, TX_SUM
	} afc_tx_e;

	afc_tx_e     ts_q, ts_d;         // Transmit state
	logic [7:0]  tbuf_q [256];       // Outgoing payload
	logic [7:0]  tcnt_q, tcnt_d;     // Bytes collected/sent
	logic [7:0]  tidx_q, tidx_d;     // Send index
	logic [7:0]  tsum_q, tsum_d;     // Outgoing sum
	logic        tesc_q, tesc_d;     // Second half of escape
	logic        tstat_q, tstat_d;   // Sending a status frame
	logic        col;                // Collecting payload
	logic [7:0]  traw;               // Byte before escaping
	logic        tneed;              // Byte needs escaping
	logic        tadv;               // Byte fully sent
	logic [15:0] tlen;               // Length field

	assign col      = ts_q == TX_IDLE && !st_req_q && framed;
	// Transparent mode hands the host's ready straight to the core
	assign tx_ready = framed ? col : ser_tx_ready;
	assign tlen     = tstat_q ? afc_pkg::STAT_LEN : {8'h00, tcnt_q};
	assign st_ack   = ts_q == TX_IDLE && st_req_q;

	// Unescaped byte for the current field
	always_comb
	begin
		case (ts_q)
			TX_LEN_HI: traw = tlen[15:8];
			TX_LEN_LO: traw = tlen[7:0];
			TX_DATA:
				if (tstat_q)
					traw = (tidx_q == '0) ? afc_pkg::STAT_TYPE
						: st_code_q;
				else
					traw = tbuf_q[tidx_q];
			TX_SUM:    traw = afc_pkg::CSUM_BASE - tsum_q;
			default:   traw = afc_pkg::START_DELIM;
		endcase
	end

	assign tneed = escmode && ts_q != TX_DELIM && ts_q != TX_IDLE
		&& (traw == afc_pkg::START_DELIM || traw == afc_pkg::ESC_BYTE
		|| traw == afc_pkg::XON_BYTE || traw == afc_pkg::XOFF_BYTE);
	assign ser_tx_valid = framed ? ts_q != TX_IDLE
		: (tx_valid && ts_q == TX_IDLE);
	assign ser_tx_data  = !framed ? tx_data
		: (tneed && !tesc_q) ? afc_pkg::ESC_BYTE
		: tneed ? (traw ^ afc_pkg::ESC_XOR) : traw;
	assign tadv = ser_tx_valid && ser_tx_ready && (!tneed || tesc_q);

	// Transmit sequencing
	always_comb
	begin
		ts_d    = ts_q;
		tcnt_d  = tcnt_q;
		tidx_d  = tidx_q;
		tsum_d  = tsum_q;
		tstat_d = tstat_q;
		tesc_d  = tesc_q;
		if (ser_tx_valid && ser_tx_ready && tneed)
			tesc_d = !tesc_q;
		case (ts_q)
			TX_IDLE:
				if (st_ack)
				begin
					tstat_d = 1'b1;
					ts_d    = TX_DELIM;
				end
				else if (col && tx_valid)
				begin
					tcnt_d = tcnt_q + 8'h01;
					if (tx_last)
						ts_d = TX_DELIM;
				end
			TX_DELIM:  if (tadv) ts_d = TX_LEN_HI;
			TX_LEN_HI: if (tadv) ts_d = TX_LEN_LO;
			TX_LEN_LO:
				if (tadv)
				begin
					ts_d   = TX_DATA;
					tidx_d = '0;
					tsum_d = '0;
				end
			TX_DATA:
				if (tadv)
				begin
					tsum_d = tsum_q + traw;
					tidx_d = tidx_q + 8'h01;
					if (tidx_q + 8'h01 == tlen[7:0])
						ts_d = TX_SUM;
				end
			default:
				if (tadv)
				begin
					ts_d    = TX_IDLE;
					// A status frame leaves a half-collected payload intact
					if (!tstat_q)
						tcnt_d = '0;
					tstat_d = 1'b0;
				end
		endcase
	end

	// Transmit registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			ts_q    <= TX_IDLE;
			tcnt_q  <= '0;
			tidx_q  <= '0;
			tsum_q  <= '0;
			tesc_q  <= 1'b0;
			tstat_q <= 1'b0;
		end
		else
		begin
			ts_q    <= ts_d;
			tcnt_q  <= tcnt_d;
			tidx_q  <= tidx_d;
			tsum_q  <= tsum_d;
			tesc_q  <= tesc_d;
			tstat_q <= tstat_d;
		end
		if (col && tx_valid)
			tbuf_q[tcnt_q] <= tx_data;
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_good_sum: assert property (@(posedge clk) disable iff (!rstn)
		rx_take && framed && rs_q == RX_SUM && rb_ok && !good_d
		&& !(escmode && !resc_q && ser_rx_data == afc_pkg::START_DELIM)
		|-> 8'(rsum_q + rb) != afc_pkg::CSUM_GOOD)
		else $error("good sum not accepted");
	chk_bad_status: assert property (@(posedge clk) disable iff (!rstn)
		bad_q && rs_q == RX_HUNT |-> st_req_q)
		else $error("bad frame without status");
	chk_hunt_drop: assert property (@(posedge clk) disable iff (!rstn)
		framed && rs_q == RX_HUNT |-> !fifo_in_v)
		else $error("byte delivered while hunting");
	chk_esc_out: assert property (@(posedge clk) disable iff (!rstn)
		ser_tx_valid && ser_tx_ready && tneed && !tesc_q
		|=> ser_tx_data == ($past(traw) ^ afc_pkg::ESC_XOR))
		else $error("escape pair wrong");
	chk_no_raw_res: assert property (@(posedge clk) disable iff (!rstn)
		escmode && ser_tx_valid && ts_q != TX_DELIM
		|-> ser_tx_data != afc_pkg::START_DELIM)
		else $error("raw delimiter inside frame");
	chk_delim_first: assert property (@(posedge clk) disable iff (!rstn)
		framed && ts_q == TX_DELIM && ser_tx_valid
		|-> ser_tx_data == afc_pkg::START_DELIM)
		else $error("frame not opened by delimiter");
	chk_abort: assert property (@(posedge clk) disable iff (!rstn)
		escmode && rx_take && !resc_q
		&& ser_rx_data == afc_pkg::START_DELIM |=> rs_q == RX_LEN_HI)
		else $error("delimiter did not restart");
	chk_bad_nodata: assert property (@(posedge clk) disable iff (!rstn)
		bad_d |-> !(fifo_in_v && fifo_in.last))
		else $error("bad frame delivered last byte");
	cov_good: cover property (@(posedge clk) good_q);
	cov_bad: cover property (@(posedge clk) bad_q);
	cov_esc: cover property (@(posedge clk) tneed && tesc_q);
	cov_stat: cover property (@(posedge clk) st_ack);

endmodule

//--- bench/afc_host_model.sv
`timescale 1ns/10ps
module afc_host_model (
	// Clock and pacing
	input  wire logic       clk,
	input  wire logic       stall,
	// Bytes to the device
	output logic            ser_rx_valid,
	output logic      [7:0] ser_rx_data,
	// Bytes from the device
	input  wire logic       ser_tx_valid,
	output logic            ser_tx_ready,
	input  wire logic [7:0] ser_tx_data
);
	// ****************************************
	// Host side of the serial port
	// ****************************************
	logic [7:0] got_q[$]; // Bytes taken from the device

	initial
	begin
		ser_rx_valid = 1'b0;
		ser_rx_data  = 8'h00;
		ser_tx_ready = 1'b0;
	end

	// One byte a cycle, no gap needed between bytes
	task automatic put(input logic [7:0] b);
		@(negedge clk);
		ser_rx_valid = 1'b1;
		ser_rx_data  = b;
	endtask

	// Idle line shows the inverse, not a stale byte
	task automatic idle();
		@(negedge clk);
		ser_rx_valid = 1'b0;
		ser_rx_data  = ~ser_rx_data;
	endtask

	// Slow host takes a byte every other cycle
	always @(negedge clk)
		ser_tx_ready <= stall ? ~ser_tx_ready : 1'b1;

	// Every frame type is kept; the bench judges them
	always @(posedge clk)
		if (ser_tx_valid && ser_tx_ready)
			got_q.push_back(ser_tx_data);
endmodule

//--- bench/api_frame_codec_tb.sv
`timescale 1ns/10ps
module api_frame_codec_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic       clk = 1'b0; // 50 MHz
	logic       rstn;       // Sync reset
	logic [1:0] mode;       // Framing mode
	logic       ser_rx_valid, ser_tx_valid, ser_tx_ready, stall;
	logic [7:0] ser_rx_data, ser_tx_data, rx_data, tx_data;
	logic       rx_valid, rx_ready, rx_last, rx_good, rx_bad;
	logic       tx_valid, tx_ready, tx_last;
	int         errors, cmp_count, n_good, n_bad, rx_mode, k;
	logic [8:0] rxq[$];     // Payload with last mark
	logic [7:0] fr[$], pl[$];

	// Table rows: inputs and expected status code (0 = good)
	typedef struct packed {
		logic [1:0]  mode;
		logic [2:0]  n;
		logic [31:0] d;
		logic [7:0]  code;
	} afc_row_s;
	afc_row_s rows [5] = '{
		'{2'h1, 3'h1, 32'h08000000, 8'h00},
		'{2'h1, 3'h4, 32'h107e1120, 8'h00},
		'{2'h1, 3'h3, 32'h08aa5500, 8'h01},
		'{2'h2, 3'h4, 32'h177e7d13, 8'h00},
		'{2'h2, 3'h2, 32'h11130000, 8'h01}};

	always #10 clk = ~clk;

	afc_codec afc_codec_i (.clk(clk), .rstn(rstn),
		.framing_mode_select(mode), .ser_rx_valid(ser_rx_valid),
		.ser_rx_data(ser_rx_data), .ser_tx_valid(ser_tx_valid),
		.ser_tx_ready(ser_tx_ready), .ser_tx_data(ser_tx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.rx_last(rx_last), .rx_good(rx_good), .rx_bad(rx_bad),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_last(tx_last));

	afc_host_model afc_host_model_i (.clk(clk), .stall(stall),
		.ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
		.ser_tx_valid(ser_tx_valid), .ser_tx_ready(ser_tx_ready),
		.ser_tx_data(ser_tx_data));

	// ****************************************
	// Core-side monitor
	// ****************************************
	// Core drains steadily, slowly, or not at all
	always @(negedge clk)
		rx_ready <= (rx_mode == 0) ? 1'b1 : (rx_mode == 1) ? ~rx_ready : 1'b0;

	always @(posedge clk)
		if (rstn)
		begin
			if (rx_valid && rx_ready)
				rxq.push_back({rx_last, rx_data});
			if (rx_good === 1'b1)
				n_good++;
			if (rx_bad === 1'b1)
				n_bad++;
		end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_q(input logic [7:0] g[$], input logic [7:0] e[$]);
		chk(16'(g.size()), 16'(e.size()));
		foreach (e[i])
			if (i < g.size())
				chk({8'h00, g[i]}, {8'h00, e[i]});
	endtask

	// Bounded wait: 0 frame events, 1 payload bytes, 2 host bytes
	task automatic wait_for(input int which, input int target);
		int i;
		for (i = 0; i < 400; i++)
		begin
			@(posedge clk);
			if ((which == 0 && n_good + n_bad >= target) ||
				(which == 1 && rxq.size() >= target) ||
				(which == 2 && afc_host_model_i.got_q.size() >= target))
				break;
		end
		if (i == 400)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, i, target);
			report_and_stop();
		end
	endtask

	task automatic do_reset(input logic [1:0] m);
		@(negedge clk);
		rstn = 1'b0;
		mode = m;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		rxq.delete();
		afc_host_model_i.got_q.delete();
		n_good = 0;
		n_bad  = 0;
	endtask

	// Frame a payload, escaping 7E, 7D, 11, 13 after the delimiter in escaped mode
	task automatic build(input logic [1:0] m, input logic [7:0] p[$],
		input logic bad);
		logic [7:0] body[$];
		logic [7:0] s;
		s = 8'h00;
		foreach (p[i])
			s += p[i];
		body = {8'h00, 8'(p.size()), p, (8'hff - s) ^ {7'h00, bad}};
		fr = {afc_pkg::START_DELIM};
		foreach (body[i])
			if (m == 2'h2 && body[i] inside {8'h7e, 8'h7d, 8'h11, 8'h13})
				fr = {fr, 8'h7d, body[i] ^ 8'h20};
			else
				fr.push_back(body[i]);
	endtask

	task automatic send();
		foreach (fr[i])
			afc_host_model_i.put(fr[i]);
		afc_host_model_i.idle();
	endtask

	// Core hands bytes in, holding each until taken
	task automatic core_send(input logic [7:0] p[$]);
		int j;
		foreach (p[i])
		begin
			@(negedge clk);
			tx_valid = 1'b1;
			tx_data  = p[i];
			tx_last  = (i == p.size() - 1);
			for (j = 0; j < 300; j++)
			begin
				@(posedge clk);
				if (tx_ready === 1'b1)
					break;
			end
			if (j == 300)
			begin
				errors++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, j, 300);
				report_and_stop();
			end
		end
		@(negedge clk);
		tx_valid = 1'b0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{rstn, tx_valid, tx_last, stall} = 4'h0;
		{mode, tx_data, errors, cmp_count, rx_mode} = '0;
		do_reset(2'h0);
		chk({ser_tx_valid, rx_valid, rx_good, rx_bad}, 4'h0);
		// Table of received frames
		foreach (rows[r])
		begin
			if (rows[r].mode !== mode)
				do_reset(rows[r].mode);
			rx_mode = 1;
			rxq.delete();
			afc_host_model_i.got_q.delete();
			{n_good, n_bad} = '0;
			pl = {};
			for (k = 0; k < rows[r].n; k++)
				pl.push_back(rows[r].d[31 - 8 * k -: 8]);
			build(rows[r].mode, pl, rows[r].code != 8'h00);
			afc_host_model_i.put(8'h55);
			send();
			wait_for(0, 1);
			wait_for(1, rows[r].n - (rows[r].code != 8'h00));
			chk(16'(n_bad), 16'(rows[r].code != 8'h00));
			chk(16'(n_good), 16'(rows[r].code == 8'h00));
			foreach (rxq[i])
				chk(rxq[i], {i == rows[r].n - 1, pl[i]});
			if (rows[r].code != 8'h00)
			begin
				build(rows[r].mode, {8'h8a, rows[r].code}, 1'b0);
				wait_for(2, fr.size());
				cmp_q(afc_host_model_i.got_q, fr);
			end
		end
		// Unescaped delimiter in mid-frame
		do_reset(2'h2);
		fr = {8'h7e, 8'h00, 8'h03, 8'haa};
		send();
		build(2'h2, {8'h08}, 1'b0);
		send();
		wait_for(0, 2);
		chk(16'(n_bad), 16'h1);
		chk(16'(n_good), 16'h1);
		build(2'h2, {8'h8a, 8'h02}, 1'b0);
		wait_for(2, fr.size());
		cmp_q(afc_host_model_i.got_q, fr);
		chk(rxq[$], 9'h108);
		// Transmit framing with a slow host
		for (k = 1; k < 3; k++)
		begin
			do_reset(2'(k));
			stall = 1'b1;
			pl = {8'h8b, 8'h7e, 8'h11};
			core_send(pl);
			build(2'(k), pl, 1'b0);
			wait_for(2, fr.size());
			cmp_q(afc_host_model_i.got_q, fr);
			stall = 1'b0;
		end
		// Transparent mode, FIFO filled past full then drained
		do_reset(2'h0);
		rx_mode = 2;
		for (k = 0; k < 10; k++)
			afc_host_model_i.put(8'(k));
		afc_host_model_i.idle();
		rx_mode = 0;
		wait_for(1, 8);
		repeat (4) @(posedge clk);
		chk(16'(rxq.size()), 16'h0008);
		for (k = 0; k < 8; k++)
			chk(rxq[k], {1'b1, 8'(k)});
		core_send({8'h5a});
		wait_for(2, 1);
		cmp_q(afc_host_model_i.got_q, {8'h5a});
		report_and_stop();
	end
endmodule
